/* File: hw/erc_pkg.sv */
// erc_pkg: shared types and constants for the encoder resolution configuration block
// assumes a single mclk domain; settings arrive from the drive parameter store
package erc_pkg;

    // encoder types
    typedef enum logic [3:0] {
        quadrature_type,
        freq_direction_type,
        forward_reverse_type,
        quadrature_commutation_type,
        freq_direction_commutation_type,
        forward_reverse_commutation_type,
        sine_cosine_type,
        sine_cosine_proto_a_type,
        sine_cosine_proto_b_type,
        sine_cosine_ssi_type,
        comms_only_proto_b_type,
        comms_only_ssi_type
    } erc_enc_e;

    localparam logic [18:0] LINES_MAX          = 19'h7a120;  // 500000
    localparam logic [18:0] LINES_RESET        = 19'h01000;  // 4096
    localparam logic [15:0] SC_POW2_MIN        = 16'h0002;
    localparam logic [15:0] SC_POW2_MAX        = 16'h8000;
    localparam logic [5:0]  COMMS_BITS_MAX     = 6'h20;      // 32
    localparam logic [5:0]  COMMS_BITS_RESET   = 6'h00;
    localparam logic [5:0]  LINEAR_PROTO_A_BITS = 6'h20;     // fixed 32
    localparam logic [3:0]  INTERP_NOMINAL     = 4'ha;
    localparam logic [3:0]  INTERP_MAX         = 4'hb;
    localparam logic [3:0]  INTERP_200K        = 4'h9;
    localparam logic [3:0]  INTERP_500K        = 4'h8;
    localparam logic [2:0]  FREQ_BAND_5K       = 3'h1;       // up to 5 kHz
    localparam logic [2:0]  FREQ_BAND_100K     = 3'h3;       // up to 100 kHz
    localparam logic [2:0]  FREQ_BAND_200K     = 3'h4;
    localparam logic [3:0]  SW_FREQ_6K         = 4'h6;
    localparam logic [3:0]  SW_FREQ_12K        = 4'hc;
    localparam logic [3:0]  SAMPLE_6K          = 4'h6;
    localparam logic [1:0]  SEL_LINEAR         = 2'h0;
    localparam int          QUAD_MAX_KHZ       = 500;        // encoder side limit

    // settings from the parameter store
    typedef struct packed {
        erc_enc_e    enc_type;
        logic [1:0]  rotary_linear_select;
        logic [18:0] equiv_lines_per_rev;
        logic [5:0]  single_turn_comms_bits;
        logic [7:0]  pole_count_map1;
        logic [7:0]  pole_count_map2;
        logic        motor_map2;
        logic [3:0]  switching_freq_report;
    } erc_cfg_s;

    // resolved configuration toward the control loop
    typedef struct packed {
        logic [18:0] equivalent_line_count;
        logic [18:0] lines_eff;
        logic        commutation_only;
        logic        marker_full_reset;
        logic [5:0]  comms_turn_bits;
        logic [5:0]  comms_total_bits;
        logic [4:0]  total_res_bits;
        logic [3:0]  interp_bits;
        logic [3:0]  current_sample_khz;
        logic        lines_ignored;
    } erc_out_s;

    // whole module state
    typedef struct packed {
        erc_cfg_s    cur;
        erc_out_s    res;
        logic        encoder_reinit_trip;
        logic        reinit_req;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        logic        valid;
    } erc_state_s;

endpackage : erc_pkg

/* File: hw/erc_core.sv */
// erc_core: resolves encoder line count and comms-bit settings, detects changes
// assumes background strobe from parameter scan on mclk, pins synchronised upstream
//
module erc_core (
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic              bg_strobe,
    input  wire logic              drive_enabled,
    input  wire erc_pkg::erc_cfg_s cfg,
    input  wire logic [2:0]        sig_freq_band,
    input  wire logic              auto_cfg_done,
    input  wire logic [18:0]       auto_lines,
    input  wire logic              auto_config_enable,
    input  wire logic              trip_clear,
    input  wire logic              status_read,
    input  wire logic [1:0]        irq_mask_wr_data,
    input  wire logic              irq_mask_wr,
    output erc_pkg::erc_out_s      res,
    output logic [18:0]            lines_writeback,
    output logic                   lines_writeback_en,
    output logic                   encoder_reinit_trip,
    output logic                   reinit_req,
    output logic [1:0]             irq_status,
    output logic                   irq
);

    erc_pkg::erc_state_s st;
    erc_pkg::erc_state_s next_st;

    function automatic logic is_pow2(input logic [18:0] v);
        return (v != 19'h0) && ((v & (v - 19'h1)) == 19'h0);
    endfunction : is_pow2

    function automatic logic [18:0] force_pow2(input logic [18:0] v);
        logic [18:0] r;
        r = {3'h0, erc_pkg::SC_POW2_MIN};
        for (int i = 1; i < 16; i++) begin
            if (v >= (19'h1 << i)) begin
                r = 19'h1 << i;
            end
        end
        if (r > {3'h0, erc_pkg::SC_POW2_MAX}) begin
            r = {3'h0, erc_pkg::SC_POW2_MAX};
        end
        return r;
    endfunction : force_pow2

    function automatic logic [4:0] log2c(input logic [18:0] v);
        logic [4:0] r;
        r = 5'h0;
        for (int i = 0; i < 19; i++) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : log2c

    function automatic logic is_sc(input erc_pkg::erc_enc_e t);
        return t inside {erc_pkg::sine_cosine_type, erc_pkg::sine_cosine_proto_a_type,
                         erc_pkg::sine_cosine_proto_b_type, erc_pkg::sine_cosine_ssi_type};
    endfunction : is_sc

    function automatic logic is_sc_comms(input erc_pkg::erc_enc_e t);
        return is_sc(t) && (t != erc_pkg::sine_cosine_type);
    endfunction : is_sc_comms

    function automatic logic is_servo(input erc_pkg::erc_enc_e t);
        return t inside {erc_pkg::quadrature_commutation_type,
                         erc_pkg::freq_direction_commutation_type,
                         erc_pkg::forward_reverse_commutation_type};
    endfunction : is_servo

    function automatic logic is_comms_only(input erc_pkg::erc_enc_e t);
        return t inside {erc_pkg::comms_only_proto_b_type, erc_pkg::comms_only_ssi_type};
    endfunction : is_comms_only

    logic [18:0] lines_in;
    logic [5:0]  bits_in;
    logic        linear;
    logic        lines_chg;
    logic        poles_chg;
    logic        take;
    logic [3:0]  interp;
    logic        do_auto;

    always_comb begin
        next_st = st;
        take    = bg_strobe && !drive_enabled;
        do_auto = auto_cfg_done && auto_config_enable;
        // settings clamp
        lines_in = (cfg.equiv_lines_per_rev > erc_pkg::LINES_MAX) ?
                   erc_pkg::LINES_MAX : cfg.equiv_lines_per_rev;
        bits_in  = (cfg.single_turn_comms_bits > erc_pkg::COMMS_BITS_MAX) ?
                   erc_pkg::COMMS_BITS_MAX : cfg.single_turn_comms_bits;
        linear   = (cfg.rotary_linear_select == erc_pkg::SEL_LINEAR);
        // auto-configuration fills line count
        if (do_auto && is_sc_comms(cfg.enc_type) &&
            cfg.enc_type != erc_pkg::sine_cosine_ssi_type) begin
            lines_in = auto_lines;
        end
        if (do_auto && is_comms_only(cfg.enc_type)) begin
            lines_in = 19'h0;
        end
        if (is_sc_comms(cfg.enc_type) && !linear) begin
            lines_in = force_pow2(lines_in);
        end
        lines_chg = take && st.valid && (lines_in != st.cur.equiv_lines_per_rev);
        poles_chg = take && st.valid &&
                    ((cfg.pole_count_map1 != st.cur.pole_count_map1) ||
                     (cfg.pole_count_map2 != st.cur.pole_count_map2) ||
                     (cfg.motor_map2 != st.cur.motor_map2));
        // interpolation at 1.2 V
        if (sig_freq_band <= erc_pkg::FREQ_BAND_5K) begin
            interp = erc_pkg::INTERP_MAX;
        end else if (sig_freq_band <= erc_pkg::FREQ_BAND_100K) begin
            interp = erc_pkg::INTERP_NOMINAL;
        end else if (sig_freq_band == erc_pkg::FREQ_BAND_200K) begin
            interp = erc_pkg::INTERP_200K;
        end else begin
            interp = erc_pkg::INTERP_500K;
        end
        // one-cycle reinit_req cleared by default; trip and status clear and mask loads only on request
        next_st.reinit_req = 1'b0;
        if (trip_clear) begin
            next_st.encoder_reinit_trip = 1'b0;
        end
        if (status_read) begin
            next_st.irq_status = 2'h0;
        end
        if (irq_mask_wr) begin
            next_st.irq_mask = irq_mask_wr_data;
        end
        if (take) begin
            next_st.valid = 1'b1;
            next_st.cur = cfg;
            next_st.cur.equiv_lines_per_rev = lines_in;
            next_st.cur.single_turn_comms_bits = bits_in;
            if (is_servo(cfg.enc_type) && (lines_chg || poles_chg)) begin
                next_st.reinit_req = 1'b1;
                next_st.irq_status[0] = 1'b1;
            end
            if (is_sc(cfg.enc_type) && lines_chg) begin
                next_st.encoder_reinit_trip = 1'b1;
                next_st.reinit_req = 1'b1;
                next_st.irq_status[1] = 1'b1;
            end
            // equivalent lines
            case (cfg.enc_type)
                erc_pkg::freq_direction_type, erc_pkg::forward_reverse_type,
                erc_pkg::freq_direction_commutation_type,
                erc_pkg::forward_reverse_commutation_type: begin
                    next_st.res.equivalent_line_count = lines_in >> 1;
                end
                default: begin
                    next_st.res.equivalent_line_count = lines_in;
                end
            endcase
            next_st.res.lines_ignored = is_comms_only(cfg.enc_type);
            next_st.res.lines_eff = is_comms_only(cfg.enc_type) ?
                                    19'h0 : next_st.res.equivalent_line_count;
            next_st.res.commutation_only = is_servo(cfg.enc_type) &&
                                           (lines_in == 19'h0);
            next_st.res.marker_full_reset = !is_sc_comms(cfg.enc_type) &&
                                            !is_comms_only(cfg.enc_type) &&
                                            (bits_in != 6'h0);
            next_st.res.comms_turn_bits = 6'h0;
            next_st.res.comms_total_bits = 6'h0;
            if (is_sc_comms(cfg.enc_type) && !linear) begin
                next_st.res.comms_turn_bits = bits_in;
            end
            if (is_sc_comms(cfg.enc_type) && linear) begin
                next_st.res.comms_total_bits =
                    (cfg.enc_type == erc_pkg::sine_cosine_proto_a_type) ?
                    erc_pkg::LINEAR_PROTO_A_BITS : bits_in;
            end
            next_st.res.current_sample_khz = cfg.switching_freq_report;
            if (linear && !is_pow2(lines_in) &&
                (cfg.switching_freq_report == erc_pkg::SW_FREQ_6K ||
                 cfg.switching_freq_report == erc_pkg::SW_FREQ_12K)) begin
                next_st.res.current_sample_khz = erc_pkg::SAMPLE_6K;
            end
        end
        next_st.res.interp_bits = is_sc(st.cur.enc_type) ? interp : 4'h0;
        next_st.res.total_res_bits = is_sc(st.cur.enc_type) ?
            5'(log2c(st.res.equivalent_line_count) + 5'(interp)) : 5'h0;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.cur.equiv_lines_per_rev <= erc_pkg::LINES_RESET;
            st.cur.single_turn_comms_bits <= erc_pkg::COMMS_BITS_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign res                 = st.res;
    assign encoder_reinit_trip = st.encoder_reinit_trip;
    assign reinit_req          = st.reinit_req;
    assign irq_status          = st.irq_status;
    assign irq                 = |(st.irq_status & st.irq_mask);
    assign lines_writeback     = st.cur.equiv_lines_per_rev;
    assign lines_writeback_en  = st.valid;

    sc_trip_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && is_sc(cfg.enc_type) && lines_chg) |=> encoder_reinit_trip && reinit_req)
        else $error("line change did not trip");
    servo_reinit_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && is_servo(cfg.enc_type) && poles_chg) |=> reinit_req)
        else $error("pole change did not re-init");
    comm_only_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && is_servo(cfg.enc_type) && lines_in == 19'h0) |=> res.commutation_only)
        else $error("zero lines not commutation only");
    pow2_force_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && is_sc_comms(cfg.enc_type) && !linear) |=>
        is_pow2(lines_writeback) && lines_writeback <= 19'h08000)
        else $error("lines not power of two");
    sample_drop_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && linear && !is_pow2(lines_in) && cfg.switching_freq_report == 4'hc)
        |=> res.current_sample_khz == 4'h6)
        else $error("sample rate not reduced");
    lines_ignore_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && is_comms_only(cfg.enc_type)) |=> res.lines_eff == 19'h0)
        else $error("comms-only lines not ignored");
    marker_mode_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && cfg.enc_type == erc_pkg::quadrature_type) |=>
        res.marker_full_reset == (st.cur.single_turn_comms_bits != 6'h0))
        else $error("marker mode wrong");
    proto_a_bits_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && linear && cfg.enc_type == erc_pkg::sine_cosine_proto_a_type)
        |=> res.comms_total_bits == 6'h20)
        else $error("linear proto a not 32 bits");
    disabled_only_a: assert property (@(posedge mclk) disable iff (!rstn)
        drive_enabled |=> $stable(lines_writeback))
        else $error("setting changed while enabled");
    half_lines_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && cfg.enc_type == erc_pkg::freq_direction_type) |=>
        res.equivalent_line_count == (lines_writeback >> 1))
        else $error("equivalent lines not halved");
    auto_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && do_auto && is_comms_only(cfg.enc_type)) |=> lines_writeback == 19'h0)
        else $error("comms-only auto-config did not zero lines");
    turn_bits_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && is_sc_comms(cfg.enc_type) && !linear) |=>
        res.comms_turn_bits == $past(bits_in))
        else $error("turn bits not taken");
    trip_status_a: assert property (@(posedge mclk) disable iff (!rstn)
        (take && is_sc(cfg.enc_type) && lines_chg) |=> irq_status[1])
        else $error("trip status not set");
    bits_clamp_a: assert property (@(posedge mclk) disable iff (!rstn)
        lines_writeback_en |-> st.cur.single_turn_comms_bits <= 6'h20)
        else $error("comms bits beyond range");
    interp_fast_a: assert property (@(posedge mclk) disable iff (!rstn)
        (sig_freq_band > 3'h4 && is_sc(st.cur.enc_type)) |=> res.interp_bits == 4'h8)
        else $error("interpolation not reduced");

endmodule : erc_core

/* File: bench/erc_enc_model.sv */
// erc_enc_model: behavioural position encoder at the far side of the block
// assumes the bench sets signal frequency and fires auto-config with a background read
module erc_enc_model (
    input  wire logic [9:0]  sig_khz,
    input  wire logic        fire,
    input  wire logic [18:0] lines_in,
    output logic [2:0]       sig_freq_band,
    output logic             auto_cfg_done,
    output logic [18:0]      auto_lines
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [9:0] khz_eff;

    // encoder never exceeds its frequency limit
    assign khz_eff = (sig_khz > 10'h1f4) ? 10'h1f4 : sig_khz;

    always_comb begin
        if (khz_eff <= 10'h001) sig_freq_band = 3'h0;
        else if (khz_eff <= 10'h005) sig_freq_band = 3'h1;
        else if (khz_eff <= 10'h032) sig_freq_band = 3'h2;
        else if (khz_eff <= 10'h064) sig_freq_band = 3'h3;
        else if (khz_eff <= 10'h0c8) sig_freq_band = 3'h4;
        else sig_freq_band = 3'h5;
    end

    // line count read out of the encoder, junk outside a read
    assign auto_cfg_done = fire;
    assign auto_lines    = fire ? lines_in : ~lines_in;
endmodule : erc_enc_model

/* File: bench/erc_core_tb.sv */
// erc_core_tb: self-checking bench for the encoder resolution configuration core
// assumes erc_pkg, erc_core and erc_enc_model are compiled before it
module erc_core_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic              mclk = 1'b0;
    logic              rstn = 1'b0;
    logic              bg_strobe = 1'b0;
    logic              drive_enabled = 1'b0;
    erc_pkg::erc_cfg_s cfg = '0;
    logic [2:0]        sig_freq_band;
    logic              auto_cfg_done;
    logic [18:0]       auto_lines;
    logic              auto_config_enable = 1'b0;
    logic              trip_clear = 1'b0;
    logic              status_read = 1'b0;
    logic [1:0]        irq_mask_wr_data = 2'h0;
    logic              irq_mask_wr = 1'b0;
    erc_pkg::erc_out_s res;
    logic [18:0]       lines_writeback;
    logic              lines_writeback_en;
    logic              encoder_reinit_trip;
    logic              reinit_req;
    logic [1:0]        irq_status;
    logic              irq;
    logic [9:0]        sig_khz = 10'h001;
    logic              fire = 1'b0;
    logic              af = 1'b0;
    logic [18:0]       enc_lines = 19'h00000;
    logic [7:0]        pl = 8'h04;
    logic [3:0]        sw = 4'h4;
    int                failures = 0;
    int                total_checks = 0;
    int                cyc = 0;
    logic [18:0]       tin [3] = '{19'h00bb8, 19'h09c40, 19'h00001};
    logic [18:0]       tout [3] = '{19'h00800, 19'h08000, 19'h00002};

    always #12.5 mclk = ~mclk;

    erc_core i_erc_core (.mclk(mclk), .rstn(rstn), .bg_strobe(bg_strobe),
        .drive_enabled(drive_enabled), .cfg(cfg), .sig_freq_band(sig_freq_band),
        .auto_cfg_done(auto_cfg_done), .auto_lines(auto_lines),
        .auto_config_enable(auto_config_enable), .trip_clear(trip_clear),
        .status_read(status_read), .irq_mask_wr_data(irq_mask_wr_data),
        .irq_mask_wr(irq_mask_wr), .res(res), .lines_writeback(lines_writeback),
        .lines_writeback_en(lines_writeback_en), .encoder_reinit_trip(encoder_reinit_trip),
        .reinit_req(reinit_req), .irq_status(irq_status), .irq(irq));

    erc_enc_model i_erc_enc_model (.sig_khz(sig_khz), .fire(fire), .lines_in(enc_lines),
        .sig_freq_band(sig_freq_band), .auto_cfg_done(auto_cfg_done),
        .auto_lines(auto_lines));

    task results;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task chk(input string n, input logic [18:0] e, input logic [18:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk

    // one background read with the given type, select, lines and comms bits
    task take(input erc_pkg::erc_enc_e t, input logic [1:0] s, input logic [18:0] l,
              input logic [5:0] b);
        erc_pkg::erc_cfg_s n;
        n = cfg;
        n.enc_type = t;
        n.rotary_linear_select = s;
        n.equiv_lines_per_rev = l;
        n.single_turn_comms_bits = b;
        n.pole_count_map1 = pl;
        n.switching_freq_report = sw;
        @(posedge mclk);
        cfg <= n;
        bg_strobe <= 1'b1;
        fire <= af;
        @(posedge mclk);
        bg_strobe <= 1'b0;
        fire <= 1'b0;
        #1;
    endtask : take

    task clr;
        @(posedge mclk);
        status_read <= 1'b1;
        trip_clear <= 1'b1;
        @(posedge mclk);
        status_read <= 1'b0;
        trip_clear <= 1'b0;
        #1;
    endtask : clr

    task mask(input logic [1:0] m);
        @(posedge mclk);
        irq_mask_wr <= 1'b1;
        irq_mask_wr_data <= m;
        @(posedge mclk);
        irq_mask_wr <= 1'b0;
        #1;
    endtask : mask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            results();
        end
    end

    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        chk("reset lines", erc_pkg::LINES_RESET, lines_writeback);
        chk("reset trip", 1'b0, encoder_reinit_trip);
        chk("reset taken", 1'b0, lines_writeback_en);
        mask(2'h3);
        take(erc_pkg::sine_cosine_type, 2'h1, 19'h00400, 6'h00);
        chk("baseline trip", 1'b0, encoder_reinit_trip);
        chk("taken flag", 1'b1, lines_writeback_en);
        repeat (2) @(posedge mclk);
        #1;
        chk("interp 1k", erc_pkg::INTERP_MAX, res.interp_bits);
        chk("total 1k", 19'h00015, res.total_res_bits);
        chk("equiv sc", 19'h00400, res.equivalent_line_count);
        sig_khz <= 10'h0c8;
        repeat (3) @(posedge mclk);
        #1;
        chk("interp 200k", erc_pkg::INTERP_200K, res.interp_bits);
        chk("total 200k", 19'h00013, res.total_res_bits);
        sig_khz <= 10'h1f4;
        take(erc_pkg::sine_cosine_type, 2'h1, 19'h00400, 6'h00);
        repeat (2) @(posedge mclk);
        #1;
        chk("interp 500k", erc_pkg::INTERP_500K, res.interp_bits);
        chk("total 500k", 19'h00012, res.total_res_bits);
        chk("no change trip", 1'b0, encoder_reinit_trip);
        take(erc_pkg::sine_cosine_type, 2'h1, 19'h003e8, 6'h00);
        chk("sc trip", 1'b1, encoder_reinit_trip);
        chk("sc reinit", 1'b1, reinit_req);
        chk("sc status", 2'h2, irq_status);
        chk("irq on", 1'b1, irq);
        @(posedge mclk);
        #1;
        chk("reinit pulse", 1'b0, reinit_req);
        clr();
        chk("status clear", 2'h0, irq_status);
        chk("irq clear", 1'b0, irq);
        chk("trip clear", 1'b0, encoder_reinit_trip);
        mask(2'h0);
        take(erc_pkg::sine_cosine_type, 2'h1, 19'h00400, 6'h00);
        chk("masked status", 2'h2, irq_status);
        chk("masked irq", 1'b0, irq);
        mask(2'h3);
        chk("unmasked irq", 1'b1, irq);
        clr();
        @(posedge mclk);
        drive_enabled <= 1'b1;
        take(erc_pkg::sine_cosine_type, 2'h1, 19'h007d0, 6'h05);
        chk("frozen trip", 1'b0, encoder_reinit_trip);
        chk("frozen lines", 19'h00400, res.equivalent_line_count);
        drive_enabled <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            take(erc_pkg::sine_cosine_proto_b_type, 2'h1, tin[i], 6'h00);
            chk("pow2 lines", tout[i], lines_writeback);
        end
        take(erc_pkg::quadrature_type, 2'h1, 19'h003e8, 6'h00);
        chk("equiv quad", 19'h003e8, res.equivalent_line_count);
        take(erc_pkg::freq_direction_type, 2'h1, 19'h003e8, 6'h00);
        chk("equiv fd", 19'h001f4, res.equivalent_line_count);
        take(erc_pkg::forward_reverse_type, 2'h1, 19'h003e8, 6'h05);
        chk("equiv fr", 19'h001f4, res.equivalent_line_count);
        chk("marker full", 1'b1, res.marker_full_reset);
        take(erc_pkg::quadrature_type, 2'h1, 19'h003e8, 6'h00);
        chk("marker plain", 1'b0, res.marker_full_reset);
        sw = erc_pkg::SW_FREQ_6K;
        take(erc_pkg::sine_cosine_type, erc_pkg::SEL_LINEAR, 19'h003e8, 6'h00);
        chk("sample 6k", erc_pkg::SAMPLE_6K, res.current_sample_khz);
        sw = erc_pkg::SW_FREQ_12K;
        take(erc_pkg::sine_cosine_type, erc_pkg::SEL_LINEAR, 19'h003e8, 6'h00);
        chk("sample 12k", erc_pkg::SAMPLE_6K, res.current_sample_khz);
        take(erc_pkg::sine_cosine_type, erc_pkg::SEL_LINEAR, 19'h00400, 6'h00);
        chk("sample pow2", erc_pkg::SW_FREQ_12K, res.current_sample_khz);
        take(erc_pkg::sine_cosine_proto_b_type, 2'h1, 19'h00400, 6'h14);
        chk("turn bits", 19'h00014, res.comms_turn_bits);
        take(erc_pkg::sine_cosine_proto_b_type, erc_pkg::SEL_LINEAR, 19'h00400, 6'h18);
        chk("total bits", 19'h00018, res.comms_total_bits);
        take(erc_pkg::sine_cosine_proto_a_type, erc_pkg::SEL_LINEAR, 19'h00400, 6'h18);
        chk("proto a bits", erc_pkg::LINEAR_PROTO_A_BITS, res.comms_total_bits);
        take(erc_pkg::quadrature_commutation_type, 2'h1, 19'h00000, 6'h00);
        chk("comm only", 1'b1, res.commutation_only);
        take(erc_pkg::quadrature_commutation_type, 2'h1, 19'h01000, 6'h00);
        clr();
        pl = 8'h05;
        take(erc_pkg::quadrature_commutation_type, 2'h1, 19'h01000, 6'h00);
        chk("pole reinit", 1'b1, reinit_req);
        chk("pole status", 2'h1, irq_status);
        clr();
        auto_config_enable <= 1'b1;
        af = 1'b1;
        enc_lines <= 19'h02000;
        take(erc_pkg::sine_cosine_proto_a_type, 2'h1, 19'h00400, 6'h00);
        chk("auto lines", 19'h02000, lines_writeback);
        take(erc_pkg::comms_only_proto_b_type, 2'h1, 19'h01388, 6'h00);
        chk("comms zero", 19'h00000, lines_writeback);
        chk("lines ignored", 1'b1, res.lines_ignored);
        af = 1'b0;
        results();
    end
endmodule : erc_core_tb
